// [asq_checker.sv]
// Port assertions for the sample queue block
`timescale 1ns/100ps
module asq_checker
   import asq_pkg::*;
(
   input wire logic       clk_in,
   input wire logic       reset_n_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic       reg_rd_in,
   input wire logic       reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic       first_interrupt_output_in,
   input wire logic       second_interrupt_output_in,
   input wire logic       watermark_flag_out,
   input wire logic       overrun_flag_out
);
   // ----
   // Properties
   // ----
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   wire wr_c  = reg_wr_in && reg_addr_in == ASQ_ADDR_CTRL;
   wire rd_c  = reg_rd_in && reg_addr_in == ASQ_ADDR_CTRL;
   wire rd_s  = reg_rd_in && reg_addr_in == ASQ_ADDR_STAT;
   wire rd_x  = reg_rd_in && reg_addr_in == ASQ_ADDR_XLO;
   wire quiet = !first_interrupt_output_in && !second_interrupt_output_in;
   wire unmap = reg_addr_in < ASQ_ADDR_XLO || reg_addr_in > ASQ_ADDR_STAT;
   property p_unmap; reg_rd_in && unmap |=> reg_rdata_out == ASQ_ZERO_BYTE; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_hold; !reg_rd_in |=> $stable(reg_rdata_out); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_ctrl; wr_c ##1 !wr_c ##1 rd_c |=> reg_rdata_out == $past(reg_wdata_in, 3);
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
   property p_bit6; rd_s |=> !reg_rdata_out[6]; endproperty
   a_bit6: assert property (p_bit6) else $error("status bit 6 set");
   property p_cnt; rd_s |=> reg_rdata_out[5:0] <= 6'h20; endproperty
   a_cnt: assert property (p_cnt) else $error("entries above depth");
   property p_wm0; wr_c && reg_wdata_in[4:0] == 5'h00 |-> ##[1:2] watermark_flag_out; endproperty
   a_wm0: assert property (p_wm0) else $error("zero count without watermark");
   property p_trig; (wr_c && quiet) ##1 quiet ##1 (rd_s && quiet) |=> !reg_rdata_out[7];
   endproperty
   a_trig: assert property (p_trig) else $error("trigger seen after rewrite");
   property p_ovr; overrun_flag_out && rd_x |-> ##[1:16] !overrun_flag_out; endproperty
   a_ovr: assert property (p_ovr) else $error("overrun kept after read");
   c_wr: cover property (wr_c);
   c_ovr: cover property ($rose(overrun_flag_out));
   c_trig: cover property (rd_s ##1 reg_rdata_out[7]);
endmodule
bind asq_top asq_checker asq_checker_inst (
   .clk_in                     (clk_in),
   .reset_n_in                 (reset_n_in),
   .reg_addr_in                (reg_addr_in),
   .reg_rd_in                  (reg_rd_in),
   .reg_wr_in                  (reg_wr_in),
   .reg_wdata_in               (reg_wdata_in),
   .reg_rdata_out              (reg_rdata_out),
   .first_interrupt_output_in  (first_interrupt_output_in),
   .second_interrupt_output_in (second_interrupt_output_in),
   .watermark_flag_out         (watermark_flag_out),
   .overrun_flag_out           (overrun_flag_out)
);

// [asq_host.sv]
// Host model on the register port
`timescale 1ns/100ps
module asq_host
   import asq_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic [7:0] reg_rdata_in,
   output logic      [7:0] reg_addr_out = 8'hA5,
   output logic            reg_rd_out = 1'b0,
   output logic            reg_wr_out = 1'b0,
   output logic      [7:0] reg_wdata_out = 8'h5A,
   output logic            xfer_end_out = 1'b0
);
   // ----
   // Transfers, released lines inverted
   // ----
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      reg_addr_out = a;
      reg_wdata_out = d;
      reg_wr_out = 1'b1;
      @(negedge clk_in);
      reg_wr_out = 1'b0;
      reg_addr_out = ~a;
      reg_wdata_out = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_in);
      reg_addr_out = a;
      reg_rd_out = 1'b1;
      @(negedge clk_in);
      reg_rd_out = 1'b0;
      reg_addr_out = ~a;
      d = reg_rdata_in;
   endtask
   task automatic burst(output logic [47:0] v);
      logic [7:0] b;
      for (int i = 0; i < 6; i++) begin
         rd(ASQ_ADDR_XLO + 8'(i), b);
         v[8*i+:8] = b;
      end
      @(negedge clk_in);
      xfer_end_out = 1'b1;
      @(negedge clk_in);
      xfer_end_out = 1'b0;
   endtask
endmodule

// [asq_pkg.sv]
// Constants and register map of the sample queue block
//------------------------------------------------------------
// Contract
// - Axis bytes at 0x32..0x37, read only
// - Two's complement, low byte at lower address
// - Control bits 7:6 select the queue mode
// - Fill mode stores 32, then stops
// - Stream mode overwrites oldest when full
// - Trigger mode keeps pre-trigger, then fills
// - Trigger select picks first or second interrupt
// - Sample count zero sets watermark at once
// - Count sets watermark level, ignored in bypass
// - Trigger mode: count is pre-trigger depth
// - Status bit 7 shows trigger seen
// - Status reports entries; bit 6 reads zero
// - Axis read removes one level; burst reads
// - 32 queued plus one output stage entry
// - Ready, overrun flags clear on read; watermark follows the level
// - Sleep stops queue pushes; data updates in bypass or with output stage empty
//------------------------------------------------------------
package asq_pkg;
   localparam int          ASQ_DEPTH      = 32;
   localparam int          ASQ_AXIS_W     = 16;
   localparam int          ASQ_SAMPLE_W   = 3 * ASQ_AXIS_W;
   localparam logic [7:0]  ASQ_ADDR_XLO   = 8'h32;
   localparam logic [7:0]  ASQ_ADDR_XHI   = 8'h33;
   localparam logic [7:0]  ASQ_ADDR_YLO   = 8'h34;
   localparam logic [7:0]  ASQ_ADDR_YHI   = 8'h35;
   localparam logic [7:0]  ASQ_ADDR_ZLO   = 8'h36;
   localparam logic [7:0]  ASQ_ADDR_ZHI   = 8'h37;
   localparam logic [7:0]  ASQ_ADDR_CTRL  = 8'h38;
   localparam logic [7:0]  ASQ_ADDR_STAT  = 8'h39;
   localparam logic [7:0]  ASQ_CTRL_RESET = 8'h00;
   localparam int          ASQ_MODE_HI    = 7;
   localparam int          ASQ_MODE_LO    = 6;
   localparam int          ASQ_TRIG_SEL   = 5;
   localparam int          ASQ_CNT_HI     = 4;
   localparam logic [1:0]  ASQ_MODE_BYP   = 2'h0;
   localparam logic [1:0]  ASQ_MODE_FILL  = 2'h1;
   localparam logic [1:0]  ASQ_MODE_STRM  = 2'h2;
   localparam logic [1:0]  ASQ_MODE_TRIG  = 2'h3;
   localparam logic [7:0]  ASQ_ZERO_BYTE  = 8'h00;
endpackage

// [asq_queue.sv]
// Flip-flop sample queue with push, pop and occupancy
`timescale 1ns/100ps
module asq_queue #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 32
) (
   input  wire logic                       clk_in,
   input  wire logic                       rst_n_in,
   input  wire logic                       push_in,
   input  wire logic [WIDTH-1:0]           data_in,
   input  wire logic                       pop_in,
   input  wire logic                       clear_in,
   output logic      [WIDTH-1:0]           head_out,
   output logic      [$clog2(DEPTH+1)-1:0] count_out
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0]    wr_ptr_r;
   logic [PW-1:0]    rd_ptr_r;
   logic [CW-1:0]    count_r;
   wire              do_pop  = pop_in && (count_r != '0);
   wire              do_push = push_in && ((count_r != CW'(DEPTH)) || do_pop);

   assign head_out  = mem_r[rd_ptr_r];
   assign count_out = count_r;

   always_ff @(posedge clk_in) begin
      if (do_push) begin
         mem_r[wr_ptr_r] <= data_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else if (clear_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (do_push) wr_ptr_r <= (wr_ptr_r == PW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         if (do_pop)  rd_ptr_r <= (rd_ptr_r == PW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         count_r <= count_r + CW'(do_push) - CW'(do_pop);
      end
   end
endmodule

// [asq_top.sv]
// Axis output registers with the 32-entry sample queue behind them
`timescale 1ns/100ps
module asq_top
   import asq_pkg::*;
#(
   parameter int DEPTH = ASQ_DEPTH
) (
   input  wire logic                  clk_in,
   input  wire logic                  reset_n_in,
   // Register port of the serial interface
   input  wire logic [7:0]            reg_addr_in,
   input  wire logic                  reg_rd_in,
   input  wire logic                  reg_wr_in,
   input  wire logic [7:0]            reg_wdata_in,
   input  wire logic                  xfer_end_in,
   output logic      [7:0]            reg_rdata_out,
   // Sample source
   input  wire logic                  sample_valid_in,
   input  wire logic [ASQ_AXIS_W-1:0] x_sample_in,
   input  wire logic [ASQ_AXIS_W-1:0] y_sample_in,
   input  wire logic [ASQ_AXIS_W-1:0] z_sample_in,
   input  wire logic                  sleep_in,
   input  wire logic                  first_interrupt_output_in,
   input  wire logic                  second_interrupt_output_in,
   // Event flags
   output logic                       data_ready_flag_out,
   output logic                       watermark_flag_out,
   output logic                       overrun_flag_out
);
   localparam int CW = $clog2(DEPTH+1);

   //------------------------------------------------------------
   // Reset release
   //------------------------------------------------------------
   logic rst_meta_r;
   logic rst_n_r;

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   //------------------------------------------------------------
   // State
   //------------------------------------------------------------
   logic [7:0]              ctrl_r;
   logic [ASQ_SAMPLE_W-1:0] out_data_r;
   logic                    out_valid_r;
   logic                    trig_seen_r;
   logic                    int_prev_r;
   logic                    axis_touched_r;
   logic                    ready_r;
   logic                    wmark_r;
   logic                    ovr_r;
   logic [7:0]              rdata_r;

   //------------------------------------------------------------
   // Decode
   //------------------------------------------------------------
   wire [1:0]  mode       = ctrl_r[ASQ_MODE_HI:ASQ_MODE_LO];
   wire        trig_sel   = ctrl_r[ASQ_TRIG_SEL];
   wire [CW-1:0] samples  = CW'(ctrl_r[ASQ_CNT_HI:0]);
   wire        byp        = (mode == ASQ_MODE_BYP);
   wire        is_fill    = (mode == ASQ_MODE_FILL);
   wire        is_strm    = (mode == ASQ_MODE_STRM);
   wire        is_trig    = (mode == ASQ_MODE_TRIG);
   wire        ctrl_wr    = reg_wr_in && (reg_addr_in == ASQ_ADDR_CTRL);
   wire        axis_rd    = reg_rd_in && (reg_addr_in >= ASQ_ADDR_XLO)
                            && (reg_addr_in <= ASQ_ADDR_ZHI);
   wire        rd_pop     = xfer_end_in && (axis_touched_r || axis_rd);
   wire [ASQ_SAMPLE_W-1:0] new_sample = {z_sample_in, y_sample_in, x_sample_in};

   // Trigger source and first-edge detection
   wire        int_sel    = trig_sel ? second_interrupt_output_in
                                     : first_interrupt_output_in;
   wire        trig_evt   = is_trig && int_sel && !int_prev_r
                            && !trig_seen_r;

   //------------------------------------------------------------
   // Queue movement
   //------------------------------------------------------------
   logic [ASQ_SAMPLE_W-1:0] q_head;
   logic [CW-1:0]           q_count;
   wire        q_full     = (q_count == CW'(DEPTH));
   wire        q_empty    = (q_count == '0);
   wire        out_free   = !out_valid_r || rd_pop;
   wire        q_move     = !byp && out_free && !q_empty;
   wire        take       = sample_valid_in && !byp && !sleep_in;
   wire        space      = !q_full || q_move;
   // Pre-trigger depth limit: drop oldest beyond the programmed count
   wire        pre_limit  = is_trig && !trig_seen_r && (q_count >= samples);
   wire        keep_last  = is_strm || (is_trig && !trig_seen_r);
   wire        drop_old   = take && !q_move
                            && ((keep_last && q_full) || pre_limit);
   wire        q_push     = take && (space || drop_old);
   wire        lost       = take && !space && !keep_last
                            && !pre_limit;
   wire        q_pop      = q_move || drop_old;
   wire        q_clear    = ctrl_wr && byp;

   asq_queue #(
      .WIDTH (ASQ_SAMPLE_W),
      .DEPTH (DEPTH)
   ) u_queue (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_r),
      .push_in   (q_push),
      .data_in   (new_sample),
      .pop_in    (q_pop),
      .clear_in  (q_clear),
      .head_out  (q_head),
      .count_out (q_count)
   );

   //------------------------------------------------------------
   // Flag conditions
   //------------------------------------------------------------
   wire        wmark_cond = (samples == '0)
                            || (!byp && !is_trig && (q_count >= samples));
   wire        bypass_new = byp && sample_valid_in;
   wire        ready_set  = byp ? (bypass_new && !sleep_in) : q_move;
   wire        ready_nxt  = ready_set || (byp ? (ready_r && !rd_pop)
                                              : (out_valid_r && !rd_pop));
   wire        ovr_set    = (bypass_new && !sleep_in && ready_r && !rd_pop)
                            || lost || (drop_old && !pre_limit);
   wire        ovr_nxt    = ovr_set || (ovr_r && !rd_pop);
   wire        out_live   = byp || (sleep_in && !out_valid_r);

   //------------------------------------------------------------
   // Read data selection
   //------------------------------------------------------------
   logic [7:0] rd_mux;

   always_comb begin
      case (reg_addr_in)
         ASQ_ADDR_XLO:  rd_mux = out_data_r[7:0];
         ASQ_ADDR_XHI:  rd_mux = out_data_r[15:8];
         ASQ_ADDR_YLO:  rd_mux = out_data_r[23:16];
         ASQ_ADDR_YHI:  rd_mux = out_data_r[31:24];
         ASQ_ADDR_ZLO:  rd_mux = out_data_r[39:32];
         ASQ_ADDR_ZHI:  rd_mux = out_data_r[47:40];
         ASQ_ADDR_CTRL: rd_mux = ctrl_r;
         ASQ_ADDR_STAT: rd_mux = {trig_seen_r, 1'b0, 6'(q_count)};
         default:       rd_mux = ASQ_ZERO_BYTE;
      endcase
   end

   //------------------------------------------------------------
   // Registers
   //------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ctrl_r <= ASQ_CTRL_RESET;
         rdata_r <= ASQ_ZERO_BYTE;
      end else begin
         if (ctrl_wr) ctrl_r <= reg_wdata_in;
         if (reg_rd_in) rdata_r <= rd_mux;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         trig_seen_r <= 1'b0;
         int_prev_r  <= 1'b0;
      end else begin
         int_prev_r  <= int_sel;
         // Event in the rewrite cycle still counts
         trig_seen_r <= trig_evt || (trig_seen_r && !ctrl_wr);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         axis_touched_r <= 1'b0;
      end else if (xfer_end_in) begin
         axis_touched_r <= 1'b0;
      end else if (axis_rd) begin
         axis_touched_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         out_data_r  <= '0;
         out_valid_r <= 1'b0;
      end else begin
         if (q_move) begin
            out_data_r  <= q_head;
            out_valid_r <= 1'b1;
         end else begin
            if (sample_valid_in && out_live) out_data_r <= new_sample;
            if (rd_pop || byp) out_valid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ready_r <= 1'b0;
         wmark_r <= 1'b0;
         ovr_r   <= 1'b0;
      end else begin
         ready_r <= ready_nxt;
         wmark_r <= wmark_cond;
         ovr_r   <= ovr_nxt;
      end
   end

   assign reg_rdata_out       = rdata_r;
   assign data_ready_flag_out = ready_r;
   assign watermark_flag_out  = wmark_r;
   assign overrun_flag_out    = ovr_r;
endmodule

// [asq_top_test.sv]
// Self-checking bench for the sample queue block
`timescale 1ns/100ps
module asq_top_test;
   import asq_pkg::*;
   logic        clk_in = 1'b0, reset_n_in = 1'b0, sv = 1'b0, slp = 1'b0, i1 = 1'b0, i2 = 1'b0;
   logic [47:0] smp = 48'h0, v, stage, q[$];
   logic [31:0] seed = 32'h00000ABE;
   logic [7:0]  a, d, rdata, wdata;
   logic        xe, rd, wr, rdy, wm, ovr;
   int          num_errors = 0, n_compared = 0, cyc = 0, sf = 0, md = 0, pc = 0, tg = 0;
   always #2.5 clk_in = ~clk_in;
   asq_top asq_top_inst (.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(a),
      .reg_rd_in(rd), .reg_wr_in(wr), .reg_wdata_in(wdata), .xfer_end_in(xe),
      .reg_rdata_out(rdata), .sample_valid_in(sv), .x_sample_in(smp[15:0]),
      .y_sample_in(smp[31:16]), .z_sample_in(smp[47:32]), .sleep_in(slp),
      .first_interrupt_output_in(i1), .second_interrupt_output_in(i2),
      .data_ready_flag_out(rdy), .watermark_flag_out(wm), .overrun_flag_out(ovr));
   asq_host asq_host_inst (.clk_in(clk_in), .reg_rdata_in(rdata), .reg_addr_out(a),
      .reg_rd_out(rd), .reg_wr_out(wr), .reg_wdata_out(wdata), .xfer_end_out(xe));
   // ----
   // Helpers and model
   // ----
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk_v(input logic [47:0] g, input logic [47:0] e);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_f(input logic g, input logic e);
      chk_v({47'h0, g}, {47'h0, e});
   endtask
   task automatic close_out();
      $display("Compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic push();
      @(negedge clk_in);
      smp = 48'({rnd(), rnd()});
      sv = 1'b1;
      if (md == 3 && tg == 0 && pc > 0 && !slp && sf != 0 && q.size() >= pc) q.delete(0);
      if (md == 0 || slp || sf == 0) stage = smp;
      else if (q.size() < ASQ_DEPTH) q.push_back(smp);
      else if (md == 2) begin
         q.delete(0);
         q.push_back(smp);
      end
      if (md != 0 && !slp) sf = 1;
      @(negedge clk_in);
      sv = 1'b0;
      @(negedge clk_in);
   endtask
   task automatic burst(input int c);
      asq_host_inst.burst(v);
      if (c != 0) chk_v(v, stage);
      if (md != 0 && q.size() > 0) stage = q.pop_front();
      else sf = 0;
      repeat (2) @(negedge clk_in);
   endtask
   task automatic wrc(input logic [7:0] c);
      asq_host_inst.wr(ASQ_ADDR_CTRL, c);
      if (md == 0) q.delete();
      if (c[7:6] == ASQ_MODE_BYP) sf = 0;
      md = int'(c[7:6]);
      pc = int'(c[4:0]);
      tg = 0;
   endtask
   task automatic st();
      asq_host_inst.rd(ASQ_ADDR_STAT, d);
   endtask
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         close_out();
      end
   end
   // ----
   // Scenarios
   // ----
   initial begin
      repeat (20) @(negedge clk_in);
      reset_n_in = 1'b1;
      repeat (4) @(negedge clk_in);
      asq_host_inst.rd(ASQ_ADDR_CTRL, d);
      chk_v(d, ASQ_CTRL_RESET);
      chk_f(wm, 1'b1);
      wrc(8'h44);
      asq_host_inst.rd(ASQ_ADDR_CTRL, d);
      chk_v(d, 8'h44);
      repeat (5) push();
      st();
      chk_v(d, 8'h04);
      chk_f(wm, 1'b1);
      burst(1);
      st();
      chk_v(d, 8'h03);
      chk_f(wm, 1'b0);
      repeat (36) push();
      st();
      chk_v(d, 8'h20);
      chk_f(ovr, 1'b1);
      burst(1);
      chk_f(ovr, 1'b0);
      push();
      st();
      chk_v(d, 8'h20);
      $display("Test fill done");
      wrc(8'h00);
      wrc(8'h00);
      wrc(8'h9F);
      repeat (40) push();
      st();
      chk_v(d, 8'h20);
      burst(1);
      burst(1);
      $display("Test stream done");
      wrc(8'h00);
      for (int k = 0; k < 2; k++) begin
         wrc(k ? 8'hE3 : 8'hC3);
         st();
         chk_f(d[7], 1'b0);
         for (int p = 0; p < 2; p++) begin
            @(negedge clk_in);
            if ((p == 0) == (k == 0)) i2 = 1'b1;
            else i1 = 1'b1;
            repeat (2) @(negedge clk_in);
            i1 = 1'b0;
            i2 = 1'b0;
            st();
            chk_f(d[7], p == 1);
         end
      end
      wrc(8'hC3);
      repeat (6) push();
      st();
      chk_v(d, 8'h03);
      chk_f(ovr, 1'b0);
      @(negedge clk_in);
      i1 = 1'b1;
      tg = 1;
      repeat (2) @(negedge clk_in);
      i1 = 1'b0;
      repeat (31) push();
      st();
      chk_v(d, 8'hA0);
      chk_f(ovr, 1'b1);
      burst(1);
      push();
      st();
      chk_v(d, 8'hA0);
      burst(1);
      $display("Test trigger done");
      wrc(8'h00);
      burst(1);
      chk_f(rdy, 1'b0);
      push();
      chk_f(rdy, 1'b1);
      asq_host_inst.wr(ASQ_ADDR_XLO, 8'hFF);
      asq_host_inst.rd(8'h3A, d);
      chk_v(d, 8'h00);
      burst(1);
      chk_f(rdy, 1'b0);
      slp = 1'b1;
      push();
      chk_f(rdy, 1'b0);
      burst(1);
      $display("Test bypass done");
      close_out();
   end
endmodule
